//--- shared/fap_defs.vh
`ifndef FAP_DEFS_VH
`define FAP_DEFS_VH
// Register byte addresses
`define FAP_ADDR_AUTO_CFG 12'h000
`define FAP_ADDR_DIRECT_CFG 12'h004
`define FAP_ADDR_DOR 12'h008
`define FAP_ADDR_DSR 12'h00C
`define FAP_ADDR_MSR 12'h010
`define FAP_ADDR_DATA 12'h014
`define FAP_ADDR_STATUS 12'h018
// Field positions
`define FAP_AUTO_EN_BIT 0
`define FAP_DIRECT_PD_BIT 0
`define FAP_DOR_RESET_N_BIT 2
`define FAP_DOR_MOTOR_LSB 4
`define FAP_DOR_MOTOR_W 4
`define FAP_DSR_RESET_BIT 7
`define FAP_DSR_PD_BIT 6
// Values
`define FAP_MSR_IDLE 8'h80
`define FAP_DOR_RESET_VAL 8'h04
`define FAP_DSR_RESET_VAL 8'h02
// Timing
`define FAP_CLK_MHZ 125
`define FAP_TIMER_MS 10
`define FAP_TIMER_CYC (`FAP_TIMER_MS * 1000 * `FAP_CLK_MHZ)
`endif

//--- logic/fap_power.v
`timescale 1ns/10ps
// Contract
// RULE1 - Auto powerdown only when auto enable bit set and all idle conditions hold
// RULE2 - Any active motor enable bit blocks auto powerdown
// RULE3 - Main status must be 80h and controller interrupt low
// RULE4 - Head unload timer must have expired
// RULE5 - Dedicated 10 ms idle timer must have expired
// RULE6 - Timer starts on enable; power down once all conditions meet
// RULE7 - Clearing auto enable cancels timer and holds block awake
// RULE8 - Host waits 8 us after auto wake before commands
// RULE9 - Host waits 8 us at 250k, 4 us at 500k after direct wake
// RULE10 - Data-rate powerdown bit overrides auto powerdown
// RULE11 - After data-rate powerdown wake, auto powerdown applies again
// RULE12 - Hardware or software reset wakes and runs normal reset
// RULE13 - Wake by register access keeps all state intact
// RULE14 - Writing any motor enable wakes; reading output register does not
// RULE15 - Reading main status wakes
// RULE16 - Reading or writing data register wakes
// RULE17 - Every wake restarts the 10 ms timer
// RULE18 - Other register accesses complete without waking, reading true status
// RULE19 - Writes to non-waking registers are kept and used after wake
// RULE20 - Drive-side pins disabled while powered down
// RULE21 - System-side pins stay active while powered down
// RULE22 - Direct powerdown via direct config register, independent of auto
// RULE23 - Other output or data-rate register writes do not wake
// RULE24 - Conditions checked every cycle; enter in first cycle all true
`include "fap_defs.vh"
module fap_power #(
  parameter TIMER_CYC = `FAP_TIMER_CYC
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [7:0] main_status_reg,
  input wire fdc_int,
  input wire head_unload_done,
  input wire [7:0] data_rd,
  output reg data_rd_stb,
  output reg data_wr_stb,
  output reg [7:0] data_wr,
  output wire [3:0] motor_en,
  output wire [1:0] data_rate,
  output wire fdc_soft_reset,
  output wire fdc_powered_down,
  output wire auto_pd_active,
  output wire drive_pins_oe_n,
  output wire fpd
);
  // ==========================================
  // State codes and sizes
  localparam ST_AWAKE = 3'b001;
  localparam ST_AUTO = 3'b010;
  localparam ST_DSR = 3'b100;
  localparam MOTOR_W = `FAP_DOR_MOTOR_W;
  localparam COND_W = 6;
  localparam [31:0] TIMER_LAST = TIMER_CYC - 1;
  // ==========================================
  // Registers
  reg auto_en_r;
  reg auto_en_nxt;
  reg direct_pd_r;
  reg direct_pd_nxt;
  reg [7:0] dor_r;
  reg [7:0] dor_nxt;
  reg [7:0] dsr_r;
  reg [7:0] dsr_nxt;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [31:0] timer_r;
  reg [31:0] timer_nxt;
  reg timer_done_r;
  reg timer_done_nxt;
  reg [31:0] rd_mux;
  reg [31:0] prdata_nxt;
  reg data_wr_stb_nxt;
  reg data_rd_stb_nxt;
  reg [7:0] data_wr_nxt;
  // ==========================================
  // Bus decode
  wire acc;
  wire wr;
  wire rd;
  wire setup_rd;
  wire hit_auto;
  wire hit_dir;
  wire hit_dor;
  wire hit_dsr;
  wire hit_msr;
  wire hit_data;
  wire hit_stat;
  wire mapped;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign hit_auto = (paddr == `FAP_ADDR_AUTO_CFG);
  assign hit_dir = (paddr == `FAP_ADDR_DIRECT_CFG);
  assign hit_dor = (paddr == `FAP_ADDR_DOR);
  assign hit_dsr = (paddr == `FAP_ADDR_DSR);
  assign hit_msr = (paddr == `FAP_ADDR_MSR);
  assign hit_data = (paddr == `FAP_ADDR_DATA);
  assign hit_stat = (paddr == `FAP_ADDR_STATUS);
  assign mapped = hit_auto | hit_dir | hit_dor | hit_dsr |
                  hit_msr | hit_data | hit_stat;
  assign pready = 1'b1; // [RULE18] [RULE21]
  assign pslverr = acc & ~mapped;
  // ==========================================
  // Wake sources
  wire [MOTOR_W-1:0] wr_motor;
  wire dor_reset;
  wire dsr_reset;
  wire sw_reset;
  wire wake_motor;
  wire wake_msr;
  wire wake_data;
  wire wake;
  wire dsr_pd_wr;
  genvar gi;
  // ==========================================
  // Motor bits of a write
  generate
    for (gi = 0; gi < MOTOR_W; gi = gi + 1) begin : g_wr_motor
      assign wr_motor[gi] = pwdata[`FAP_DOR_MOTOR_LSB + gi];
    end
  endgenerate
  assign dor_reset = wr & hit_dor & ~pwdata[`FAP_DOR_RESET_N_BIT];
  assign dsr_reset = wr & hit_dsr & pwdata[`FAP_DSR_RESET_BIT];
  assign sw_reset = dor_reset | dsr_reset; // [RULE12]
  assign wake_motor = wr & hit_dor & (|wr_motor); // [RULE14] [RULE23]
  assign wake_msr = rd & hit_msr; // [RULE15]
  assign wake_data = acc & hit_data; // [RULE16]
  assign wake = wake_motor | wake_msr | wake_data | sw_reset; // [RULE18]
  assign dsr_pd_wr = wr & hit_dsr & pwdata[`FAP_DSR_PD_BIT];
  // ==========================================
  // Config next values, retained in any state except the DSR powerdown bit, cleared on a wake in ST_DSR
  always @* begin
    auto_en_nxt = auto_en_r;
    if (wr & hit_auto) begin
      auto_en_nxt = pwdata[`FAP_AUTO_EN_BIT];
    end
  end
  always @* begin
    direct_pd_nxt = direct_pd_r;
    if (wr & hit_dir) begin
      direct_pd_nxt = pwdata[`FAP_DIRECT_PD_BIT]; // [RULE22]
    end
  end
  always @* begin
    dor_nxt = dor_r;
    if (wr & hit_dor) begin
      dor_nxt = pwdata[7:0]; // [RULE19]
    end
  end
  always @* begin
    dsr_nxt = dsr_r;
    if (wr & hit_dsr) begin
      dsr_nxt = {1'b0, pwdata[6:0]}; // [RULE19]
    end else if ((state_r == ST_DSR) && wake) begin
      dsr_nxt[`FAP_DSR_PD_BIT] = 1'b0;
    end
  end
  // ==========================================
  // Config flops
  always @(posedge clk) begin
    if (rst) begin
      auto_en_r <= 1'b0;
    end else begin
      auto_en_r <= auto_en_nxt;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      direct_pd_r <= 1'b0;
    end else begin
      direct_pd_r <= direct_pd_nxt;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      dor_r <= `FAP_DOR_RESET_VAL;
    end else begin
      dor_r <= dor_nxt;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      dsr_r <= `FAP_DSR_RESET_VAL;
    end else begin
      dsr_r <= dsr_nxt;
    end
  end
  // ==========================================
  // Config outputs
  generate
    for (gi = 0; gi < MOTOR_W; gi = gi + 1) begin : g_motor
      assign motor_en[gi] = dor_r[`FAP_DOR_MOTOR_LSB + gi];
    end
  endgenerate
  assign data_rate = dsr_r[1:0];
  assign fdc_soft_reset = rst | sw_reset; // [RULE12]
  // ==========================================
  // Idle timer
  always @* begin
    timer_nxt = timer_r;
    timer_done_nxt = timer_done_r;
    if (!auto_en_r || wake) begin
      timer_nxt = 32'h0; // [RULE7] [RULE17]
      timer_done_nxt = 1'b0;
    end else if ((state_r == ST_AWAKE) && !timer_done_r) begin
      if (timer_r == TIMER_LAST) begin
        timer_done_nxt = 1'b1; // [RULE5] [RULE6]
      end else begin
        timer_nxt = timer_r + 32'h1;
      end
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      timer_r <= 32'h0;
      timer_done_r <= 1'b0;
    end else begin
      timer_r <= timer_nxt;
      timer_done_r <= timer_done_nxt;
    end
  end
  // ==========================================
  // Idle conditions
  wire [COND_W-1:0] idle_cond;
  wire idle_ok;
  assign idle_cond[0] = auto_en_r; // [RULE1]
  assign idle_cond[1] = ~(|motor_en); // [RULE2]
  assign idle_cond[2] = (main_status_reg == `FAP_MSR_IDLE); // [RULE3]
  assign idle_cond[3] = ~fdc_int; // [RULE3]
  assign idle_cond[4] = head_unload_done; // [RULE4]
  assign idle_cond[5] = timer_done_r; // [RULE5]
  assign idle_ok = &idle_cond; // [RULE1]
  // ==========================================
  // Power state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_AWAKE: begin
        if (dsr_pd_wr) begin
          state_nxt = ST_DSR;
        end else if (idle_ok && !wake) begin
          state_nxt = ST_AUTO; // [RULE24] [RULE6]
        end
      end
      ST_AUTO: begin
        if (dsr_pd_wr) begin
          state_nxt = ST_DSR; // [RULE10]
        end else if (wake || !auto_en_r) begin
          state_nxt = ST_AWAKE; // [RULE13] [RULE7]
        end
      end
      ST_DSR: begin
        if (wake) begin
          state_nxt = ST_AWAKE; // [RULE11]
        end
      end
      default: begin
        state_nxt = ST_AWAKE;
      end
    endcase
  end
  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_AWAKE; // [RULE12]
    end else begin
      state_r <= state_nxt;
    end
  end
  // ==========================================
  // Powerdown outputs
  assign auto_pd_active = (state_r == ST_AUTO);
  assign fdc_powered_down = (state_r != ST_AWAKE) | direct_pd_r; // [RULE22]
  assign drive_pins_oe_n = fdc_powered_down; // [RULE20]
  assign fpd = fdc_powered_down;
  // ==========================================
  // Register words
  wire [31:0] word_auto;
  wire [31:0] word_dir;
  wire [31:0] word_dor;
  wire [31:0] word_dsr;
  wire [31:0] word_msr;
  wire [31:0] word_data;
  wire [31:0] word_stat;
  assign word_auto = {31'h0, auto_en_r};
  assign word_dir = {31'h0, direct_pd_r};
  assign word_dor = {24'h0, dor_r}; // [RULE18]
  assign word_dsr = {24'h0, dsr_r};
  assign word_msr = {24'h0, main_status_reg};
  assign word_data = {24'h0, data_rd};
  assign word_stat = {29'h0, state_r};
  // ==========================================
  // Read mux
  always @* begin
    rd_mux = 32'h0;
    case (1'b1)
      hit_auto: begin
        rd_mux = word_auto;
      end
      hit_dir: begin
        rd_mux = word_dir;
      end
      hit_dor: begin
        rd_mux = word_dor;
      end
      hit_dsr: begin
        rd_mux = word_dsr;
      end
      hit_msr: begin
        rd_mux = word_msr;
      end
      hit_data: begin
        rd_mux = word_data;
      end
      hit_stat: begin
        rd_mux = word_stat;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end
  // ==========================================
  // Read capture at the setup edge
  always @* begin
    prdata_nxt = prdata;
    if (setup_rd) begin
      prdata_nxt = rd_mux; // [RULE18]
    end
  end
  // ==========================================
  // Data port strobes
  always @* begin
    data_wr_stb_nxt = wr & hit_data;
    data_rd_stb_nxt = rd & hit_data;
    data_wr_nxt = data_wr;
    if (wr & hit_data) begin
      data_wr_nxt = pwdata[7:0];
    end
  end
  // ==========================================
  // Bus flops
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else begin
      prdata <= prdata_nxt;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      data_rd_stb <= 1'b0;
      data_wr_stb <= 1'b0;
      data_wr <= 8'h00;
    end else begin
      data_rd_stb <= data_rd_stb_nxt;
      data_wr_stb <= data_wr_stb_nxt;
      data_wr <= data_wr_nxt;
    end
  end
endmodule // fap_power

//--- bench/fap_power_monitor.sv
`timescale 1ns/10ps
// ====================
// Power checks
module fap_power_monitor (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [7:0] main_status_reg,
  input wire fdc_int,
  input wire head_unload_done,
  input wire [3:0] motor_en,
  input wire fdc_powered_down,
  input wire auto_pd_active,
  input wire drive_pins_oe_n,
  input wire fpd
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  a_idle_status: assert property ($rose(auto_pd_active) |-> $past(main_status_reg) == 8'h80 && !$past(fdc_int))
    else $error("busy entry");
  a_head_done: assert property ($rose(auto_pd_active) |-> $past(head_unload_done))
    else $error("head entry");
  a_motor_off: assert property ($rose(auto_pd_active) |-> motor_en == 4'h0)
    else $error("motor entry");
  a_pins_off: assert property (fdc_powered_down |-> drive_pins_oe_n && fpd)
    else $error("pins on");
  a_bus_live: assert property (acc |-> pready)
    else $error("no ready");
  a_data_wake: assert property (acc && paddr == 12'h014 |-> ##2 !auto_pd_active)
    else $error("data no wake");
  a_status_wake: assert property (rd && paddr == 12'h010 |-> ##2 !auto_pd_active)
    else $error("status no wake");
  a_out_read: assert property (auto_pd_active && rd && paddr == 12'h008 |=> auto_pd_active)
    else $error("read woke");
  a_timer_restart: assert property ($fell(auto_pd_active) |-> !auto_pd_active [*8])
    else $error("early entry");
  a_off_clear: assert property (acc && pwrite && paddr == 12'h000 && !pwdata[0] |-> ##2 !auto_pd_active [*4])
    else $error("disabled entry");
endmodule // fap_power_monitor
bind fap_power fap_power_monitor i_mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .main_status_reg(main_status_reg), .fdc_int(fdc_int),
  .head_unload_done(head_unload_done), .motor_en(motor_en), .fdc_powered_down(fdc_powered_down),
  .auto_pd_active(auto_pd_active), .drive_pins_oe_n(drive_pins_oe_n), .fpd(fpd));

//--- bench/fap_ctrl_model.sv
`timescale 1ns/10ps
// ====================
// Controller core stand-in
module fap_ctrl_model (
  input wire clk,
  input wire busy,
  output reg [7:0] main_status_reg,
  output reg fdc_int,
  output reg head_unload_done,
  output reg [7:0] data_rd
);
  initial {main_status_reg, fdc_int, head_unload_done, data_rd} = 18'h0;
  always @(posedge clk) begin
    main_status_reg <= busy ? 8'h90 : 8'h80;
    fdc_int <= busy;
    head_unload_done <= !busy;
    data_rd <= $urandom;
  end
endmodule // fap_ctrl_model

//--- bench/tb.sv
`timescale 1ns/10ps
// ====================
// Bench
module tb;
  reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, busy = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rv;
  localparam WAIT_250K = 1000;
  localparam WAIT_AUTO = 1000;
  localparam LIMIT = 6000;
  wire pready, fdc_int, head_unload_done;
  wire pslverr, data_wr_stb, fdc_soft_reset, fdc_powered_down, auto_pd_active, drive_pins_oe_n, fpd;
  wire [3:0] motor_en;
  wire [1:0] data_rate;
  wire [7:0] data_wr;
  wire [31:0] prdata;
  wire [7:0] main_status_reg, data_rd;
  integer bad_count = 0, tests_run = 0, cyc = 0;
  logic [31:0] q[$];
  always #4 clk = ~clk;
  fap_ctrl_model i_ctl (.clk, .busy, .main_status_reg, .fdc_int, .head_unload_done, .data_rd);
  fap_power #(.TIMER_CYC(20)) i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .main_status_reg, .fdc_int, .head_unload_done, .data_rd, .data_rd_stb(), .data_wr_stb,
    .data_wr, .motor_en, .data_rate, .fdc_soft_reset, .fdc_powered_down, .auto_pd_active,
    .drive_pins_oe_n, .fpd);
  task end_of_test;
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(d);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input [31:0] e);
    tests_run = tests_run + 1;
    if (prdata !== e) begin
      bad_count = bad_count + 1;
      $display("BAD %0t exp %h got %h", $time, e, prdata);
    end
  endtask
  task chk_pin(input [7:0] e, input [7:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
    if (psel && penable && pready === 1'b1 && !pwrite) chk(q.pop_front());
    if (psel && penable && pready === 1'b1) chk_pin({7'h0, paddr == 12'h020}, {7'h0, pslverr});
    if (psel && penable && pwrite && paddr == 12'h00C) chk_pin({7'h0, pwdata[7]}, {7'h0, fdc_soft_reset});
  end
  initial begin
    rv = $urandom(86209);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(0, 12'h018, 32'h1);
    apb(0, 12'h008, 32'h4);
    apb(1, 12'h004, 32'h1);
    @(negedge clk);
    chk_pin(8'h07, {5'h0, fpd, fdc_powered_down, drive_pins_oe_n});
    apb(1, 12'h004, 32'h0);
    repeat (WAIT_250K) @(posedge clk);
    @(negedge clk);
    chk_pin(8'h00, {5'h0, fpd, fdc_powered_down, drive_pins_oe_n});
    apb(1, 12'h000, 32'h1);
    repeat (40) @(posedge clk);
    apb(0, 12'h018, 32'h2);
    @(negedge clk);
    chk_pin(8'h01, {7'h0, auto_pd_active});
    rv = {$urandom} & 32'h0B | 32'h04;
    apb(1, 12'h008, rv);
    apb(0, 12'h008, rv);
    apb(0, 12'h018, 32'h2);
    apb(0, 12'h010, 32'h80);
    apb(0, 12'h018, 32'h1);
    repeat (WAIT_AUTO) @(posedge clk);
    apb(0, 12'h018, 32'h2);
    apb(1, 12'h008, 32'h14);
    @(negedge clk);
    chk_pin(8'h01, {4'h0, motor_en});
    apb(0, 12'h018, 32'h1);
    repeat (40) @(posedge clk);
    apb(0, 12'h018, 32'h1);
    busy <= 1'b1;
    apb(1, 12'h008, 32'h4);
    repeat (40) @(posedge clk);
    apb(0, 12'h018, 32'h1);
    busy <= 1'b0;
    repeat (40) @(posedge clk);
    apb(0, 12'h018, 32'h2);
    apb(1, 12'h014, rv);
    @(negedge clk);
    chk_pin(rv[7:0], data_wr);
    chk_pin(8'h01, {7'h0, data_wr_stb});
    apb(0, 12'h018, 32'h1);
    repeat (40) @(posedge clk);
    apb(1, 12'h00C, 32'h42);
    @(negedge clk);
    chk_pin(8'h02, {6'h0, data_rate});
    chk_pin(8'h01, {7'h0, fdc_powered_down});
    apb(0, 12'h018, 32'h4);
    apb(0, 12'h010, 32'h80);
    repeat (40) @(posedge clk);
    apb(0, 12'h018, 32'h2);
    apb(1, 12'h000, 32'h0);
    apb(0, 12'h018, 32'h1);
    apb(1, 12'h00C, 32'h80);
    apb(0, 12'h020, 32'h0);
    end_of_test;
  end
endmodule // tb
